// File: temp_monitor_smbus_slave_alert_tb_top.sv
`timescale 1ns/1ps
module temp_monitor_smbus_slave_alert_tb_top;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg valid = 1'b0;
  reg ack;
  reg [1:0] sel = 2'h0;
  reg [7:0] temp = 8'h00;
  reg [7:0] rtemp = 8'h00;
  reg ropen = 1'b0;
  reg [7:0] rx;
  reg [7:0] pulses = 8'h00;
  reg [7:0] base;
  wire scl, pull, oe, start, stby, alert;
  wire [2:0] rate;
  wire sda = ~(pull | oe);
  integer error_cnt = 0;
  integer tests_run = 0;
  integer i;
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i)
    if (start)
      pulses <= pulses + 8'h01;
  tmss_slave u_tmss_slave (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .scl_i(scl),
    .serial_data_line_i(sda),
    .serial_data_line_o(),
    .serial_data_line_oe_o(oe),
    .addr_sel_i(sel),
    .local_temp_i(temp),
    .remote_temp_i(rtemp),
    .remote_open_i(ropen),
    .meas_valid_i(valid),
    .adc_busy_i(1'b0),
    .conv_start_o(start),
    .standby_o(stby),
    .conv_rate_o(rate),
    .alert_o(),
    .alert_oe_o(alert)
  );
  tmss_host_model u_tmss_host_model (
    .clock_i(clock_i),
    .sda_i(sda),
    .scl_o(scl),
    .sda_pull_o(pull)
  );
  task chk(input [8*10-1:0] name, input [7:0] exp, input [7:0] seen);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0s exp %h got %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] ptr, input [7:0] d, input integer n);
    begin
      u_tmss_host_model.frame(8'h9c, ptr, d, n, ack, rx);
      chk("wr_ack", 8'h01, {7'h00, ack});
    end
  endtask
  task rd(input [6:0] a, input ak, input [7:0] exp);
    begin
      u_tmss_host_model.frame({a, 1'b1}, 8'hff, 8'hff, 1, ack, rx);
      chk("rd_ack", {7'h00, ak}, {7'h00, ack});
      if (ak)
        chk("rd_data", exp, rx);
    end
  endtask
  // Readings only count once the valid pulse has been taken
  task meas(input [7:0] t);
    begin
      temp = t;
      valid = 1'b1;
      u_tmss_host_model.tick(1);
      valid = 1'b0;
      u_tmss_host_model.tick(4);
    end
  endtask
  task final_report;
    begin
      $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 3; i = i + 1) begin
      sel = i[1:0];
      rst_i = 1'b1;
      u_tmss_host_model.tick(10);
      rst_i = 1'b0;
      rd(7'h4c + i[6:0], 1'b1, 8'h00);
      rd(7'h4f, 1'b0, 8'h00);
    end
    chk("rst_out", 8'h02, {stby, alert, 3'h0, rate});
    sel = 2'h0;
    rd(7'h4e, 1'b1, 8'h00);
    wr(8'h05, 8'h00, 1);
    rd(7'h4e, 1'b1, 8'h7f);
    rd(7'h4e, 1'b1, 8'h7f);
    wr(8'h06, 8'h00, 1);
    rd(7'h4e, 1'b1, 8'hc9);
    wr(8'h0b, 8'h20, 2);
    rd(7'h4e, 1'b1, 8'h00);
    wr(8'h05, 8'h00, 1);
    rd(7'h4e, 1'b1, 8'h20);
    meas(8'h20);
    chk("alert_eq", 8'h00, {7'h00, alert});
    meas(8'h21);
    chk("alert_hi", 8'h01, {7'h00, alert});
    rd(7'h0c, 1'b1, 8'h9c);
    chk("alert_kept", 8'h01, {7'h00, alert});
    meas(8'h10);
    wr(8'h02, 8'h00, 1);
    rd(7'h4e, 1'b1, 8'h40);
    chk("alert_stat", 8'h01, {7'h00, alert});
    rd(7'h0c, 1'b1, 8'h9c);
    chk("alert_clr", 8'h00, {7'h00, alert});
    rd(7'h0c, 1'b0, 8'h00);
    ropen = 1'b1;
    rtemp = 8'h30;
    meas(8'h10);
    chk("alert_open", 8'h01, {7'h00, alert});
    ropen = 1'b0;
    meas(8'h10);
    wr(8'h01, 8'h00, 1);
    rd(7'h4e, 1'b1, 8'h30);
    wr(8'h02, 8'h00, 1);
    rd(7'h4e, 1'b1, 8'h04);
    rd(7'h0c, 1'b1, 8'h9c);
    chk("open_clr", 8'h00, {7'h00, alert});
    meas(8'h21);
    wr(8'h09, 8'h80, 2);
    chk("alert_mask", 8'h00, {7'h00, alert});
    wr(8'h09, 8'hc0, 2);
    chk("standby", 8'h01, {7'h00, stby});
    base = pulses;
    wr(8'h0f, 8'ha5, 2);
    chk("one_shot", 8'h01, pulses - base);
    rd(7'h4e, 1'b1, 8'h00);
    final_report;
  end
endmodule

// File: tmss_defines.vh
`ifndef TMSS_DEFINES_VH
`define TMSS_DEFINES_VH

// ----------------------------------------
// Register pointers, read side
// ----------------------------------------
`define TMSS_RD_LOCAL 8'h00
`define TMSS_RD_REMOTE 8'h01
`define TMSS_RD_STATUS 8'h02
`define TMSS_RD_CONFIG 8'h03
`define TMSS_RD_RATE 8'h04
`define TMSS_RD_LHIGH 8'h05
`define TMSS_RD_LLOW 8'h06
`define TMSS_RD_RHIGH 8'h07
`define TMSS_RD_RLOW 8'h08
`define TMSS_RD_MFR_ID 8'hfe
`define TMSS_RD_DIE_REV 8'hff

// ----------------------------------------
// Register pointers, write side
// ----------------------------------------
`define TMSS_WR_CONFIG 8'h09
`define TMSS_WR_RATE 8'h0a
`define TMSS_WR_LHIGH 8'h0b
`define TMSS_WR_LLOW 8'h0c
`define TMSS_WR_RHIGH 8'h0d
`define TMSS_WR_RLOW 8'h0e
`define TMSS_WR_ONE_SHOT 8'h0f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TMSS_RST_VALUE 8'h00
`define TMSS_RST_CONFIG 8'h00
`define TMSS_RST_RATE 8'h02
`define TMSS_RST_HIGH 8'h7f
`define TMSS_RST_LOW 8'hc9
`define TMSS_RST_PTR 8'h00

// ----------------------------------------
// Bus addresses and field positions
// ----------------------------------------
`define TMSS_ADDR_GND 7'h4c
`define TMSS_ADDR_NC 7'h4d
`define TMSS_ADDR_VDD 7'h4e
`define TMSS_ADDR_ARA 7'h0c
`define TMSS_SEL_GND 2'h0
`define TMSS_SEL_VDD 2'h2
`define TMSS_CFG_MASK_BIT 7
`define TMSS_CFG_STBY_BIT 6
`define TMSS_RATE_BITS 3

`endif

// File: tmss_host_model.sv
`timescale 1ns/1ps
module tmss_host_model (
  input wire clock_i,
  input wire sda_i,
  output reg scl_o = 1'b1,
  output reg sda_pull_o = 1'b0
);
  // -------------
  // Bus master
  // -------------
  // The clock stands high between frames; data moves with clock low except at START and STOP
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock_i);
      #1;
    end
  endtask
  task xfer(input [8:0] d, output [8:0] q);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        sda_pull_o = ~d[i];
        tick(2);
        scl_o = 1'b1;
        tick(2);
        q[i] = sda_i;
        tick(2);
        scl_o = 1'b0;
        tick(2);
      end
    end
  endtask
  // A read is sent as a byte of ones, so its ninth bit is a no-acknowledge
  task frame(input [7:0] hdr, input [7:0] b1, input [7:0] b2, input integer n, output ack, output [7:0] rx);
    reg [8:0] q;
    begin
      tick(4);
      sda_pull_o = 1'b1;
      tick(4);
      scl_o = 1'b0;
      tick(2);
      xfer({hdr, 1'b1}, q);
      ack = ~q[0];
      if (ack && n > 0)
        xfer({b1, 1'b1}, q);
      if (ack && n > 1)
        xfer({b2, 1'b1}, q);
      rx = q[8:1];
      sda_pull_o = 1'b1;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_pull_o = 1'b0;
      tick(8);
    end
  endtask
endmodule

// File: tmss_limit_cmp.v
`timescale 1ns/1ps
module tmss_limit_cmp (
  input wire [7:0] value_i,
  input wire [7:0] high_i,
  input wire [7:0] low_i,
  output wire high_trip_o,
  output wire low_trip_o
);
  // Readings and limits are two's complement degrees
  assign high_trip_o = $signed(value_i) > $signed(high_i);
  assign low_trip_o = $signed(value_i) < $signed(low_i);
endmodule

// File: tmss_monitor.sv
`timescale 1ns/1ps
module tmss_monitor (
  input wire clock_i,
  input wire rst_i,
  input wire scl_i,
  input wire serial_data_line_o,
  input wire serial_data_line_oe_o,
  input wire conv_start_o,
  input wire standby_o,
  input wire [2:0] conv_rate_o,
  input wire alert_o,
  input wire alert_oe_o
);
  // --------------
  // Idle detector
  // --------------
  // A clock high this long is only seen between frames
  reg [3:0] hi_cnt;
  always @(posedge clock_i) begin
    if (rst_i || !scl_i)
      hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hf)
      hi_cnt <= hi_cnt + 4'h1;
  end
  wire idle = hi_cnt > 4'hb;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  property p_oe_low; $changed(serial_data_line_oe_o) |-> !$past(scl_i); endproperty
  a_oe_low: assert property (p_oe_low) else $error("data pull moved with clock high");
  property p_drain; !serial_data_line_o && !alert_o; endproperty
  a_drain: assert property (p_drain) else $error("open drain pin driven high");
  property p_idle; idle |-> !serial_data_line_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("data pulled on idle bus");
  property p_shot1; conv_start_o |=> !conv_start_o; endproperty
  a_shot1: assert property (p_shot1) else $error("start pulse too long");
  property p_shot_stby; conv_start_o |-> standby_o; endproperty
  a_shot_stby: assert property (p_shot_stby) else $error("start pulse outside standby");
  property p_quiet; idle |-> $stable(conv_rate_o) && $stable(standby_o) && !conv_start_o; endproperty
  a_quiet: assert property (p_quiet) else $error("control changed on idle bus");
  property p_latch; idle |-> !$fell(alert_oe_o); endproperty
  a_latch: assert property (p_latch) else $error("alert released on idle bus");
  property p_rst;
    $fell(rst_i) |-> conv_rate_o == 3'h2 && !standby_o && !alert_oe_o && !serial_data_line_oe_o;
  endproperty
  a_rst: assert property (p_rst) else $error("output not at reset value");
endmodule
bind tmss_slave tmss_monitor u_tmss_monitor (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .scl_i(scl_i),
  .serial_data_line_o(serial_data_line_o),
  .serial_data_line_oe_o(serial_data_line_oe_o),
  .conv_start_o(conv_start_o),
  .standby_o(standby_o),
  .conv_rate_o(conv_rate_o),
  .alert_o(alert_o),
  .alert_oe_o(alert_oe_o)
);

// File: tmss_slave.v
`timescale 1ns/1ps
`include "tmss_defines.vh"
// What this block does
// - High alarm only when reading exceeds high limit; low alarm only below low limit.
// - Separate writable, readable high and low limits for local and remote channels.
// - One-shot write in standby starts exactly one conversion, then standby resumes.
// - Only the one-shot write access triggers; its data byte is dropped.
// - Select pin gives address 1001100 grounded, 1001101 open, 1001110 to supply.
// - Select pin is caught once after reset; later changes are ignored.
// - START is data falling with clock high; then 7 address bits MSB first, direction.
// - Matching address is acknowledged low before ninth clock; otherwise stay idle.
// - Direction zero means master writes; one means master reads.
// - Nine clocks a byte; data moves with clock low; data rising, clock high is STOP.
// - Transaction is read or write only; writes take one or more bytes, reads go on while the master acknowledges.
// - First write byte loads the pointer; a second byte goes to that register.
// - Reads return the register at the held pointer, kept across transactions.
// - Read and write pointers differ; write pointers return no register data.
// - Open-drain alert pulls low on limit trip or open sensor, else undriven.
// - Alerting device acknowledges alert response address reads, returns own address.
// - Lowest address wins alert response arbitration; loser keeps alert for later.
// - Alert released after answering only if its cause has cleared.
// - Local limits at read 05, 06 and write 0B, 0C; high limit resets 7Fh.
// - Pointer 0F is the write-only one-shot trigger.
// - Configuration bit 7 set masks the alert output; zero enables; resets zero.
// - Status reads leave alert latch alone; only serviced, cleared causes release it.
module tmss_slave #(
  parameter [7:0] MFR_ID = 8'h5a,
  parameter [7:0] DIE_REV = 8'h01
) (
  input wire clock_i,
  input wire rst_i,
  input wire scl_i,
  input wire serial_data_line_i,
  output wire serial_data_line_o,
  output wire serial_data_line_oe_o,
  input wire [1:0] addr_sel_i,
  input wire [7:0] local_temp_i,
  input wire [7:0] remote_temp_i,
  input wire remote_open_i,
  input wire meas_valid_i,
  input wire adc_busy_i,
  output reg conv_start_o,
  output wire standby_o,
  output wire [2:0] conv_rate_o,
  output wire alert_o,
  output wire alert_oe_o
);
  // MFR_ID and DIE_REV defaults are arbitrary values
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_AACK = 7'h04;
  localparam [6:0] S_RX = 7'h08;
  localparam [6:0] S_WACK = 7'h10;
  localparam [6:0] S_TX = 7'h20;
  localparam [6:0] S_RACK = 7'h40;

  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  wire l_hi_trip;
  wire l_lo_trip;
  wire r_hi_trip;
  wire r_lo_trip;

  reg [6:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg byte_done_reg;
  reg first_byte_reg;
  reg ara_reg;
  reg lost_reg;
  reg sda_oe_reg;
  reg [7:0] ptr_reg;
  reg [7:0] local_reg;
  reg [7:0] remote_reg;
  reg [7:0] config_reg;
  reg [7:0] rate_reg;
  reg [7:0] lhigh_reg;
  reg [7:0] llow_reg;
  reg [7:0] rhigh_reg;
  reg [7:0] rlow_reg;
  reg [4:0] flags_reg;
  reg open_reg;
  reg alert_reg;
  reg [6:0] dev_addr_reg;
  reg strap_taken_reg;
  reg [7:0] rd_data;
  reg scl_rise_reg;
  reg addr_full_reg;

  // ----------------------------------------
  // Bus sampling
  // ----------------------------------------
  tmss_sync u_scl_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(scl_i),
    .level_o(scl_lvl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
  );
  tmss_sync u_sda_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(serial_data_line_i),
    .level_o(sda_lvl),
    .rise_o(sda_rise),
    .fall_o(sda_fall)
  );

  // ----------------------------------------
  // Limit comparisons on the stored readings
  // ----------------------------------------
  tmss_limit_cmp u_local_cmp (
    .value_i(local_reg),
    .high_i(lhigh_reg),
    .low_i(llow_reg),
    .high_trip_o(l_hi_trip),
    .low_trip_o(l_lo_trip)
  );
  tmss_limit_cmp u_remote_cmp (
    .value_i(remote_reg),
    .high_i(rhigh_reg),
    .low_i(rlow_reg),
    .high_trip_o(r_hi_trip),
    .low_trip_o(r_lo_trip)
  );

  wire [4:0] cond_now = {l_hi_trip, l_lo_trip, r_hi_trip, r_lo_trip, open_reg};
  wire start_seen = sda_fall & scl_lvl;
  wire stop_seen = sda_rise & scl_lvl;
  wire alert_pending = alert_reg & ~config_reg[`TMSS_CFG_MASK_BIT];
  wire addr_hit = (shift_reg[7:1] == dev_addr_reg);
  wire ara_hit = (shift_reg[7:1] == `TMSS_ADDR_ARA) & shift_reg[0] & alert_pending;
  wire wr_byte = byte_done_reg & ~first_byte_reg;

  // Selected pin level to bus address
  function [6:0] sel_to_addr;
    input [1:0] sel;
    begin
      case (sel)
        `TMSS_SEL_GND: sel_to_addr = `TMSS_ADDR_GND;
        `TMSS_SEL_VDD: sel_to_addr = `TMSS_ADDR_VDD;
        default: sel_to_addr = `TMSS_ADDR_NC;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Read data select; write pointers read as zero
  // ----------------------------------------
  always @* begin
    case (ptr_reg)
      `TMSS_RD_LOCAL: rd_data = local_reg;
      `TMSS_RD_REMOTE: rd_data = remote_reg;
      `TMSS_RD_STATUS: rd_data = {adc_busy_i, flags_reg, 2'h0};
      `TMSS_RD_CONFIG: rd_data = config_reg;
      `TMSS_RD_RATE: rd_data = rate_reg;
      `TMSS_RD_LHIGH: rd_data = lhigh_reg;
      `TMSS_RD_LLOW: rd_data = llow_reg;
      `TMSS_RD_RHIGH: rd_data = rhigh_reg;
      `TMSS_RD_RLOW: rd_data = rlow_reg;
      `TMSS_RD_MFR_ID: rd_data = MFR_ID;
      `TMSS_RD_DIE_REV: rd_data = DIE_REV;
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Address strap, caught once after reset
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      dev_addr_reg <= `TMSS_ADDR_NC;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      dev_addr_reg <= sel_to_addr(addr_sel_i);
      strap_taken_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Serial protocol engine
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      byte_done_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      ara_reg <= 1'b0;
      lost_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_rise_reg <= 1'b0;
      addr_full_reg <= 1'b0;
    end else begin
      byte_done_reg <= 1'b0;
      scl_rise_reg <= scl_rise; // Bits taken a cycle late, so data that moved with the clock edge has settled
      if (start_seen) begin
        state_reg <= S_ADDR;
        bit_cnt_reg <= 3'h0;
        sda_oe_reg <= 1'b0;
        ara_reg <= 1'b0;
        lost_reg <= 1'b0;
        addr_full_reg <= 1'b0;
      end else if (stop_seen) begin
        state_reg <= S_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: sda_oe_reg <= 1'b0;
          S_ADDR: begin
            if (scl_rise_reg) begin
              shift_reg <= {shift_reg[6:0], sda_lvl};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              addr_full_reg <= (bit_cnt_reg == 3'h7);
            end else if (scl_fall && addr_full_reg) begin // The fall that follows START carries no bit
              if (addr_hit || ara_hit) begin
                sda_oe_reg <= 1'b1;
                ara_reg <= ara_hit & ~addr_hit;
                state_reg <= S_AACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              if (shift_reg[0]) begin
                // Alert answer carries the address with a zero direction bit
                tx_reg <= ara_reg ? {dev_addr_reg, 1'b0} : rd_data;
                sda_oe_reg <= ara_reg ? ~dev_addr_reg[6] : ~rd_data[7];
                state_reg <= S_TX;
              end else begin
                sda_oe_reg <= 1'b0;
                first_byte_reg <= 1'b1;
                state_reg <= S_RX;
              end
              bit_cnt_reg <= 3'h0;
            end
          end
          S_RX: begin
            if (scl_rise_reg) begin
              shift_reg <= {shift_reg[6:0], sda_lvl};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end else if (scl_fall && bit_cnt_reg == 3'h0) begin
              sda_oe_reg <= 1'b1;
              byte_done_reg <= 1'b1;
              state_reg <= S_WACK;
            end
          end
          S_WACK: begin
            first_byte_reg <= 1'b0;
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              state_reg <= S_RX;
            end
          end
          S_TX: begin
            if (scl_rise_reg) begin
              // Released one seen low means another device won
              if (!sda_oe_reg && !sda_lvl) begin
                lost_reg <= 1'b1;
                state_reg <= S_IDLE;
              end
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == 3'h0) begin
                sda_oe_reg <= 1'b0;
                state_reg <= S_RACK;
              end else begin
                sda_oe_reg <= ~tx_reg[3'h7 - bit_cnt_reg];
              end
            end
          end
          S_RACK: begin
            if (scl_rise_reg) begin
              if (sda_lvl) begin
                state_reg <= S_IDLE;
              end else begin
                tx_reg <= rd_data;
                state_reg <= S_AACK;
              end
              ara_reg <= 1'b0;
            end
          end
          default: begin
            state_reg <= S_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // A won answer ends on the ninth clock rise, whatever the master acknowledges
  wire ara_done = (state_reg == S_RACK) & scl_rise_reg & ara_reg & ~lost_reg;
  wire status_read = (state_reg == S_AACK) & scl_fall & shift_reg[0] & ~ara_reg & (ptr_reg == `TMSS_RD_STATUS);
  wire one_shot = wr_byte & (ptr_reg == `TMSS_WR_ONE_SHOT) & standby_o;

  // ----------------------------------------
  // Register file and alarm state
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      ptr_reg <= `TMSS_RST_PTR;
      local_reg <= `TMSS_RST_VALUE;
      remote_reg <= `TMSS_RST_VALUE;
      config_reg <= `TMSS_RST_CONFIG;
      rate_reg <= `TMSS_RST_RATE;
      lhigh_reg <= `TMSS_RST_HIGH;
      llow_reg <= `TMSS_RST_LOW;
      rhigh_reg <= `TMSS_RST_HIGH;
      rlow_reg <= `TMSS_RST_LOW;
      flags_reg <= 5'h00;
      open_reg <= 1'b0;
      alert_reg <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= one_shot;
      if (byte_done_reg && first_byte_reg) begin
        ptr_reg <= shift_reg;
      end
      if (wr_byte) begin
        case (ptr_reg)
          `TMSS_WR_CONFIG: config_reg <= shift_reg;
          `TMSS_WR_RATE: rate_reg <= shift_reg;
          `TMSS_WR_LHIGH: lhigh_reg <= shift_reg;
          `TMSS_WR_LLOW: llow_reg <= shift_reg;
          `TMSS_WR_RHIGH: rhigh_reg <= shift_reg;
          `TMSS_WR_RLOW: rlow_reg <= shift_reg;
          default: ;
        endcase
      end
      if (meas_valid_i) begin
        local_reg <= local_temp_i;
        remote_reg <= remote_temp_i;
        open_reg <= remote_open_i;
      end
      // Set wins over the read clear; a live cause keeps its flag
      flags_reg <= (status_read ? (flags_reg & cond_now) : flags_reg) | cond_now;
      // Status reads never touch the latch
      if (|flags_reg) begin
        alert_reg <= 1'b1;
      end else if (ara_done && cond_now == 5'h00) begin
        alert_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pins and loose outputs
  // ----------------------------------------
  assign serial_data_line_o = 1'b0;
  assign serial_data_line_oe_o = sda_oe_reg;
  assign alert_o = 1'b0;
  assign alert_oe_o = alert_pending;
  assign standby_o = config_reg[`TMSS_CFG_STBY_BIT];
  assign conv_rate_o = rate_reg[`TMSS_RATE_BITS-1:0];
endmodule

// File: tmss_sync.v
`timescale 1ns/1ps
module tmss_sync (
  input wire clock_i,
  input wire rst_i,
  input wire pin_i,
  output reg level_o,
  output wire rise_o,
  output wire fall_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // ----------------------------------------
  // Three stages, level moves when the last two agree
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level_o <= 1'b1;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end

  assign rise_o = (s2_reg == s3_reg) & s3_reg & ~level_o;
  assign fall_o = (s2_reg == s3_reg) & ~s3_reg & level_o;
endmodule
